// ==== hdl/gpef_consts.vh ====
// Register offsets, field positions, reset values and slicing levels of the two-port block
`ifndef GPEF_CONSTS_VH
`define GPEF_CONSTS_VH
// Register offsets (byte addresses on the plain port)
`define GPEF_ADDR_E_LATCH   8'h08
`define GPEF_ADDR_F_LATCH   8'h09
`define GPEF_ADDR_E_DIR     8'h0C
`define GPEF_ADDR_F_DIR     8'h0D
`define GPEF_ADDR_OPT       8'h0E
`define GPEF_ADDR_E_KBD     8'h10
`define GPEF_ADDR_F_KBD     8'h11
`define GPEF_ADDR_F_PULL    8'h12
`define GPEF_ADDR_TIM_CFG   8'h13
// Optical register fields
`define GPEF_OPT_EN_X       0
`define GPEF_OPT_EN_Y       1
`define GPEF_OPT_REFX_LO    2
`define GPEF_OPT_REFY_LO    5
// Keyboard enable register of port E: irq enables [3:0], pull-ups [7:4]
`define GPEF_KBD_PULL_LO    4
// Timer pin-claim register fields
`define GPEF_TIM_CH0        0
`define GPEF_TIM_CH1        1
`define GPEF_TIM_CLK        2
// Reset values
`define GPEF_DIR_E_RST      5'h00
`define GPEF_DIR_F_RST      8'h00
`define GPEF_REG8_RST       8'h00
// Slicing levels in mV
`define GPEF_SLICE_BASE_MV  200
`define GPEF_SLICE_STEP_MV  100
`endif

// ==== hdl/gpef_ports.v ====
// Five-bit and eight-bit software ports with timer sharing, pull-ups, keyboard routing and optical control
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "gpef_consts.vh"
//
// Overview of operation
// - Five-bit port: latch and direction per pin
// - Direction one enables output buffer
// - Reset clears five-bit direction register
// - Read returns latch if output, pin otherwise
// - Latch always writable; inputs read pins
// - Channel-claimed pins 2,1 take timer direction; clock-claimed pin 0 is input
// - Direction bit still selects read source
// - Pins 2,1 serve timer channels 1,0
// - Pin 0 feeds timer external clock
// - Pull-ups on pins 3..0 only as inputs
// - Irq enables route pins 3..0 to keyboard
// - Optical: enables low two, levels upper six
// - X enable powers pins 0,1 interface
// - Y enable powers pins 2,3 interface
// - Level code 0..7 gives 200..900 mV
// - Eight-bit port: latch, direction enables buffer
// - Reset clears eight-bit direction register
// - Eight-bit read: latch if output, else pin
// - Reset leaves eight-bit latches untouched
// - Eight-bit pull-ups as inputs, irq enables
// - Eight-bit irq enable routes pin to keyboard
//
// Register map, byte addresses; narrow registers use the low bits, upper bits read zero
//   0x08 five-bit port latch, read mixes latch and pin per direction bit
//   0x09 eight-bit port latch, same read mix
//   0x0C five-bit port direction, one drives the pin
//   0x0D eight-bit port direction, one drives the pin
//   0x0E optical control: bit 0 X enable, bit 1 Y enable, 4:2 X level, 7:5 Y level
//   0x10 five-bit keyboard register: 3:0 irq enables, 7:4 pull-up enables
//   0x11 eight-bit keyboard irq enables
//   0x12 eight-bit pull-up enables
//   0x13 timer claim: bit 0 channel 0 on pin 1, bit 1 channel 1 on pin 2, bit 2 clock on pin 0
//
// Read data stand for one cycle after the strobe and are zero otherwise; no access waits.
// Pin levels reach the read mux about four clocks after the pin settles, so a read
// straight after a pin change may still show the old level.
// The data latches carry no reset; software should load a latch before turning its pin
// into an output, or the pin briefly drives whatever the latch held.
//
module gpef_ports
#(
  parameter E_W = 5,
  parameter F_W = 8
)
(
  // Clock and reset
  input  wire           clk_in,
  input  wire           resetn_in,
  // Register port
  input  wire [7:0]     addr_in,
  input  wire [7:0]     wdata_in,
  input  wire           wr_in,
  input  wire           rd_in,
  output reg  [7:0]     rdata_out,
  // Five-bit port pins
  input  wire [E_W-1:0] e_pin_in,
  output reg  [E_W-1:0] e_pin_out,
  output reg  [E_W-1:0] e_pin_oe_out,
  output reg  [3:0]     e_pullup_out,
  output reg  [3:0]     e_kbd_src_out,
  // Timer sharing
  input  wire [1:0]     tim_ch_dir_in,
  input  wire [1:0]     tim_ch_out_in,
  output reg  [1:0]     tim_ch_in_out,
  output reg            tim_ext_clk_out,
  // Optical interface control
  output reg            opt_en_x_out,
  output reg            opt_en_y_out,
  output reg  [2:0]     slice_level_x_out,
  output reg  [2:0]     slice_level_y_out,
  // Eight-bit port pins
  input  wire [F_W-1:0] f_pin_in,
  output reg  [F_W-1:0] f_pin_out,
  output reg  [F_W-1:0] f_pin_oe_out,
  output reg  [F_W-1:0] f_pullup_out,
  output reg  [F_W-1:0] f_kbd_src_out
);

// Slicing level of a code, in mV, for the analog side to use
function integer gpef_slice_mv;
  input [2:0] code;
  begin
    gpef_slice_mv = `GPEF_SLICE_BASE_MV + `GPEF_SLICE_STEP_MV * code;
  end
endfunction

// ------------------------------------------------------------
// Registers
// ------------------------------------------------------------
reg [E_W-1:0] five_bit_port_latch_ff;
reg [E_W-1:0] five_bit_port_direction_ff;
reg [F_W-1:0] eight_bit_port_latch_ff;
reg [F_W-1:0] eight_bit_port_direction_ff;
reg [7:0]     optical_iface_enable_reg_ff;
reg [7:0]     five_bit_port_kbd_enable_reg_ff;
reg [F_W-1:0] eight_bit_port_kbd_enable_reg_ff;
reg [F_W-1:0] eight_bit_port_pullup_en_ff;
reg [2:0]     tim_claim_ff;
reg [E_W-1:0] e_s1_ff;
reg [E_W-1:0] e_s2_ff;
reg [E_W-1:0] e_s3_ff;
reg [E_W-1:0] e_lvl_ff;
reg [F_W-1:0] f_s1_ff;
reg [F_W-1:0] f_s2_ff;
reg [F_W-1:0] f_s3_ff;
reg [F_W-1:0] f_lvl_ff;

// Keyboard register of the five-bit port splits into irq enables and pull-up enables
wire [3:0] five_bit_port_kbd_irq_en = five_bit_port_kbd_enable_reg_ff[3:0];
wire [3:0] five_bit_port_pullup_en  = five_bit_port_kbd_enable_reg_ff[`GPEF_KBD_PULL_LO+3:`GPEF_KBD_PULL_LO];

// ------------------------------------------------------------
// Pin synchronisers
// ------------------------------------------------------------
// Three stages per pin; a level is accepted only when stages two and three agree.
// Stage one may be metastable, so stage two is its only reader. A pin that toggles
// every clock never agrees and the accepted level simply holds, which filters noise.
always @(posedge clk_in or negedge resetn_in)
begin
  if (!resetn_in)
  begin
    e_s1_ff  <= {E_W{1'b0}};
    e_s2_ff  <= {E_W{1'b0}};
    e_s3_ff  <= {E_W{1'b0}};
    e_lvl_ff <= {E_W{1'b0}};
  end
  else
  begin
    e_s1_ff  <= e_pin_in;
    e_s2_ff  <= e_s1_ff;
    e_s3_ff  <= e_s2_ff;
    // Agreeing stages load the level, disagreeing stages keep the old one
    e_lvl_ff <= (e_s2_ff & e_s3_ff) | (e_lvl_ff & (e_s2_ff ^ e_s3_ff));
  end
end

// Same filter for the eight-bit port
always @(posedge clk_in or negedge resetn_in)
begin
  if (!resetn_in)
  begin
    f_s1_ff  <= {F_W{1'b0}};
    f_s2_ff  <= {F_W{1'b0}};
    f_s3_ff  <= {F_W{1'b0}};
    f_lvl_ff <= {F_W{1'b0}};
  end
  else
  begin
    f_s1_ff  <= f_pin_in;
    f_s2_ff  <= f_s1_ff;
    f_s3_ff  <= f_s2_ff;
    f_lvl_ff <= (f_s2_ff & f_s3_ff) | (f_lvl_ff & (f_s2_ff ^ f_s3_ff));
  end
end

// ------------------------------------------------------------
// Control registers
// ------------------------------------------------------------
// Direction and configuration registers have reset values
// Unmapped addresses fall through to the default and change nothing
always @(posedge clk_in or negedge resetn_in)
begin
  if (!resetn_in)
  begin
    five_bit_port_direction_ff       <= `GPEF_DIR_E_RST;
    eight_bit_port_direction_ff      <= `GPEF_DIR_F_RST;
    optical_iface_enable_reg_ff      <= `GPEF_REG8_RST;
    five_bit_port_kbd_enable_reg_ff  <= `GPEF_REG8_RST;
    eight_bit_port_kbd_enable_reg_ff <= `GPEF_REG8_RST;
    eight_bit_port_pullup_en_ff      <= `GPEF_REG8_RST;
    tim_claim_ff                     <= 3'h0;
  end
  else if (wr_in)
  begin
    case (addr_in)
      `GPEF_ADDR_E_DIR:   five_bit_port_direction_ff       <= wdata_in[E_W-1:0];
      `GPEF_ADDR_F_DIR:   eight_bit_port_direction_ff      <= wdata_in[F_W-1:0];
      // full byte holds enables and levels
      `GPEF_ADDR_OPT:     optical_iface_enable_reg_ff      <= wdata_in;
      `GPEF_ADDR_E_KBD:   five_bit_port_kbd_enable_reg_ff  <= wdata_in;
      `GPEF_ADDR_F_KBD:   eight_bit_port_kbd_enable_reg_ff <= wdata_in[F_W-1:0];
      `GPEF_ADDR_F_PULL:  eight_bit_port_pullup_en_ff      <= wdata_in[F_W-1:0];
      `GPEF_ADDR_TIM_CFG: tim_claim_ff                     <= wdata_in[2:0];
      default:            tim_claim_ff                     <= tim_claim_ff;
    endcase
  end
end

// Data latches have no reset, so their contents survive a reset
// A write lands whatever the direction, so software can preload before driving
always @(posedge clk_in)
begin
  if (wr_in)
  begin
    if (addr_in == `GPEF_ADDR_E_LATCH)
      five_bit_port_latch_ff <= wdata_in[E_W-1:0];
    if (addr_in == `GPEF_ADDR_F_LATCH)
      eight_bit_port_latch_ff <= wdata_in[F_W-1:0];
  end
end

// ------------------------------------------------------------
// Read path
// ------------------------------------------------------------
// Per-bit mux of latch and accepted pin level; unmapped reads give zero
// The mux reads the filtered level, never the raw pin, so a read cannot go metastable
reg [7:0] nxt_rdata;
always @*
begin
  nxt_rdata = 8'h00;
  case (addr_in)
    // latch when output, pin when input
    // direction picks source even under timer
    `GPEF_ADDR_E_LATCH: nxt_rdata[E_W-1:0] = (five_bit_port_direction_ff & five_bit_port_latch_ff) |
                                             (~five_bit_port_direction_ff & e_lvl_ff);
    `GPEF_ADDR_F_LATCH: nxt_rdata[F_W-1:0] = (eight_bit_port_direction_ff & eight_bit_port_latch_ff) |
                                             (~eight_bit_port_direction_ff & f_lvl_ff);
    `GPEF_ADDR_E_DIR:   nxt_rdata[E_W-1:0] = five_bit_port_direction_ff;
    `GPEF_ADDR_F_DIR:   nxt_rdata[F_W-1:0] = eight_bit_port_direction_ff;
    `GPEF_ADDR_OPT:     nxt_rdata          = optical_iface_enable_reg_ff;
    `GPEF_ADDR_E_KBD:   nxt_rdata          = five_bit_port_kbd_enable_reg_ff;
    `GPEF_ADDR_F_KBD:   nxt_rdata[F_W-1:0] = eight_bit_port_kbd_enable_reg_ff;
    `GPEF_ADDR_F_PULL:  nxt_rdata[F_W-1:0] = eight_bit_port_pullup_en_ff;
    `GPEF_ADDR_TIM_CFG: nxt_rdata[2:0]     = tim_claim_ff;
    default:            nxt_rdata          = 8'h00;
  endcase
end

// Read data stands only in the cycle after the strobe
// Returning zero between reads keeps stale data off the shared bus
always @(posedge clk_in or negedge resetn_in)
begin
  if (!resetn_in)
    rdata_out <= 8'h00;
  else if (rd_in)
    rdata_out <= nxt_rdata;
  else
    rdata_out <= 8'h00;
end

// ------------------------------------------------------------
// Pin drive and sharing
// ------------------------------------------------------------
// Combinational next values; outputs are registered below
// Timer claims override the direction register only for the pin that the
// claim names; the read mux is untouched, so software still picks latch or pin.
reg [E_W-1:0] nxt_e_oe;
reg [E_W-1:0] nxt_e_out;
reg [1:0]     nxt_tim_in;
reg           nxt_tim_clk;
always @*
begin
  nxt_e_oe  = five_bit_port_direction_ff;
  nxt_e_out = five_bit_port_latch_ff;
  if (tim_claim_ff[`GPEF_TIM_CH0])
  begin
    nxt_e_oe[1]  = tim_ch_dir_in[0];
    nxt_e_out[1] = tim_ch_out_in[0];
  end
  if (tim_claim_ff[`GPEF_TIM_CH1])
  begin
    nxt_e_oe[2]  = tim_ch_dir_in[1];
    nxt_e_out[2] = tim_ch_out_in[1];
  end
  // Capture inputs read zero while the channel is not claimed
  nxt_tim_in = {e_lvl_ff[2] & tim_claim_ff[`GPEF_TIM_CH1], e_lvl_ff[1] & tim_claim_ff[`GPEF_TIM_CH0]};
  // pin 0 feeds external timer clock
  nxt_tim_clk = e_lvl_ff[0] & tim_claim_ff[`GPEF_TIM_CLK];
  if (tim_claim_ff[`GPEF_TIM_CLK])
    nxt_e_oe[0] = 1'b0;
end

// Five-bit pin drive, pull-ups and keyboard routing, one cycle behind the controls
always @(posedge clk_in or negedge resetn_in)
begin
  if (!resetn_in)
  begin
    e_pin_out     <= {E_W{1'b0}};
    e_pin_oe_out  <= {E_W{1'b0}};
    e_pullup_out  <= 4'h0;
    e_kbd_src_out <= 4'h0;
  end
  else
  begin
    // latch value, or timer output on claimed pins, to the pin driver
    e_pin_out     <= nxt_e_out;
    e_pin_oe_out  <= nxt_e_oe;
    // pull-up only while input
    // Effective enable, so a timer-driven pin never fights its own pull-up
    e_pullup_out  <= five_bit_port_pullup_en & ~nxt_e_oe[3:0];
    e_kbd_src_out <= five_bit_port_kbd_irq_en & e_lvl_ff[3:0];
  end
end

// Timer capture and clock inputs taken from the filtered pin levels
always @(posedge clk_in or negedge resetn_in)
begin
  if (!resetn_in)
  begin
    tim_ch_in_out   <= 2'h0;
    tim_ext_clk_out <= 1'b0;
  end
  else
  begin
    // captures gated so an idle channel sees no edges
    tim_ch_in_out   <= nxt_tim_in;
    // clock follows pin 0 only while claimed
    tim_ext_clk_out <= nxt_tim_clk;
  end
end

// Optical controls; levels leave as codes, the analog side turns them into millivolts
always @(posedge clk_in or negedge resetn_in)
begin
  if (!resetn_in)
  begin
    opt_en_x_out      <= 1'b0;
    opt_en_y_out      <= 1'b0;
    slice_level_x_out <= 3'h0;
    slice_level_y_out <= 3'h0;
  end
  else
  begin
    // enables at bits 0 and 1
    opt_en_x_out      <= optical_iface_enable_reg_ff[`GPEF_OPT_EN_X];
    opt_en_y_out      <= optical_iface_enable_reg_ff[`GPEF_OPT_EN_Y];
    // level fields at 4:2 and 7:5
    slice_level_x_out <= optical_iface_enable_reg_ff[`GPEF_OPT_REFX_LO+2:`GPEF_OPT_REFX_LO];
    slice_level_y_out <= optical_iface_enable_reg_ff[`GPEF_OPT_REFY_LO+2:`GPEF_OPT_REFY_LO];
  end
end

// Eight-bit pin drive, pull-ups and keyboard routing
always @(posedge clk_in or negedge resetn_in)
begin
  if (!resetn_in)
  begin
    f_pin_out     <= {F_W{1'b0}};
    f_pin_oe_out  <= {F_W{1'b0}};
    f_pullup_out  <= {F_W{1'b0}};
    f_kbd_src_out <= {F_W{1'b0}};
  end
  else
  begin
    f_pin_out     <= eight_bit_port_latch_ff;
    f_pin_oe_out  <= eight_bit_port_direction_ff;
    f_pullup_out  <= eight_bit_port_pullup_en_ff & ~eight_bit_port_direction_ff;
    f_kbd_src_out <= eight_bit_port_kbd_enable_reg_ff & f_lvl_ff;
  end
end

endmodule

// ==== tb/gpef_pin_model.sv ====
// Pin-side model of the external world for one port
`timescale 1ns/1ps
module gpef_pin_model
#(
  parameter W = 5
)
(
  input  wire         clk_in,
  input  wire [W-1:0] out_in,
  input  wire [W-1:0] oe_in,
  input  wire [W-1:0] pull_in,
  input  wire [W-1:0] ext_val_in,
  input  wire [W-1:0] ext_en_in,
  output wire [W-1:0] pin_out
);
  // Undriven, unpulled pins toggle every clock, so the port filter holds their last accepted level
  logic [W-1:0] float_ff = '0;
  always @(posedge clk_in)
    float_ff <= ~float_ff;
  // Device drive wins, then outside drive, then pull-up or floating
  assign pin_out = (oe_in & out_in) | (~oe_in & ext_en_in & ext_val_in)
                 | (~oe_in & ~ext_en_in & (pull_in | float_ff));
endmodule

// ==== tb/gpef_ports_assertions.sv ====
// Concurrent checks on the two-port block's ports
`timescale 1ns/1ps
`include "gpef_consts.vh"
module gpef_ports_chk
(
  input  wire       clk_in,
  input  wire       resetn_in,
  input  wire [7:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  input  wire [7:0] rdata_out,
  input  wire [4:0] e_pin_oe_out,
  input  wire [3:0] e_pullup_out,
  input  wire [7:0] f_pin_oe_out,
  input  wire [7:0] f_pullup_out,
  input  wire       opt_en_x_out,
  input  wire       opt_en_y_out,
  input  wire [2:0] slice_level_x_out,
  input  wire [2:0] slice_level_y_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  AST_RD_IDLE: assert property (!rd_in |=> rdata_out == 8'h00) else $error("read data not idle");
  AST_RD_UNMAP: assert property (rd_in && addr_in == 8'h20 |=> rdata_out == 8'h00) else $error("unmapped read");
  AST_E_DIR: assert property (wr_in && addr_in == `GPEF_ADDR_E_DIR |-> ##2
    e_pin_oe_out[4:3] == $past(wdata_in[4:3], 2)) else $error("port E enable mismatch");
  AST_F_DIR: assert property (wr_in && addr_in == `GPEF_ADDR_F_DIR |-> ##2 f_pin_oe_out == $past(wdata_in, 2))
    else $error("port F enable mismatch");
  AST_E_PULL: assert property ((e_pullup_out & e_pin_oe_out[3:0]) == 4'h0) else $error("E pull-up on output");
  AST_F_PULL: assert property ((f_pullup_out & f_pin_oe_out) == 8'h00) else $error("F pull-up on output");
  AST_OPT: assert property (wr_in && addr_in == `GPEF_ADDR_OPT |-> ##2
    {slice_level_y_out, slice_level_x_out, opt_en_y_out, opt_en_x_out} == $past(wdata_in, 2))
    else $error("optical fields mismatch");
  // Checked while reset is asserted, so this one is never disabled
  AST_RST_DIR: assert property (disable iff (1'b0)
    !resetn_in |-> e_pin_oe_out == 5'h00 && f_pin_oe_out == 8'h00) else $error("outputs enabled in reset");
endmodule
bind gpef_ports gpef_ports_chk u_chk (.clk_in, .resetn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
  .e_pin_oe_out, .e_pullup_out, .f_pin_oe_out, .f_pullup_out, .opt_en_x_out, .opt_en_y_out,
  .slice_level_x_out, .slice_level_y_out);

// ==== tb/tb.sv ====
// Self-checking bench for the two-port block
`timescale 1ns/1ps
`include "gpef_consts.vh"
module tb;
  logic clk_in = 0, resetn_in = 1, wr_in = 0, rd_in = 0;
  logic [7:0] addr_in = 0, wdata_in = 0, f_ext = 0, f_en = 8'hFF, rd_v;
  logic [4:0] e_ext = 0, e_en = 5'h1F;
  logic [1:0] tim_dir = 0, tim_out = 0;
  wire [4:0] e_pin, e_out, e_oe;
  wire [3:0] e_pull, e_kbd;
  wire [7:0] f_pin, f_out, f_oe, f_pull, f_kbd;
  wire [1:0] tim_in;
  wire timer_ext_clock_pin, ox, oy;
  wire [2:0] sx, sy;
  wire [7:0] rdata_out;
  int n_mismatch = 0, n_checks = 0;
  always #50 clk_in = ~clk_in;
  gpef_ports uut (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .e_pin_in(e_pin), .e_pin_out(e_out), .e_pin_oe_out(e_oe),
    .e_pullup_out(e_pull), .e_kbd_src_out(e_kbd), .tim_ch_dir_in(tim_dir), .tim_ch_out_in(tim_out),
    .tim_ch_in_out(tim_in), .tim_ext_clk_out(timer_ext_clock_pin), .opt_en_x_out(ox), .opt_en_y_out(oy),
    .slice_level_x_out(sx), .slice_level_y_out(sy), .f_pin_in(f_pin), .f_pin_out(f_out),
    .f_pin_oe_out(f_oe), .f_pullup_out(f_pull), .f_kbd_src_out(f_kbd));
  gpef_pin_model #(.W(5)) u_e (.clk_in(clk_in), .out_in(e_out), .oe_in(e_oe), .pull_in({1'b0, e_pull}),
    .ext_val_in(e_ext), .ext_en_in(e_en), .pin_out(e_pin));
  gpef_pin_model #(.W(8)) u_f (.clk_in(clk_in), .out_in(f_out), .oe_in(f_oe), .pull_in(f_pull),
    .ext_val_in(f_ext), .ext_en_in(f_en), .pin_out(f_pin));
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in) {wr_in, addr_in, wdata_in} <= {1'b1, a, d};
    @(posedge clk_in) wr_in <= 1'b0;
  endtask
  // Data stand in the cycle after the strobe only
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in) {rd_in, addr_in} <= {1'b1, a};
    @(posedge clk_in) rd_in <= 1'b0;
    @(negedge clk_in) rd_v = rdata_out;
  endtask
  task automatic settle();
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  task automatic t_reset_vals();
    rd(`GPEF_ADDR_E_DIR); chk("e_dir", rd_v, 8'h00);
    rd(`GPEF_ADDR_F_DIR); chk("f_dir", rd_v, 8'h00);
    rd(`GPEF_ADDR_OPT); chk("opt", rd_v, 8'h00);
    wr(8'h20, 8'hFF); rd(8'h20); chk("unmapped", rd_v, 8'h00);
  endtask
  task automatic t_port_e();
    e_ext <= 5'h0A; wr(`GPEF_ADDR_E_LATCH, 8'h15); settle();
    rd(`GPEF_ADDR_E_LATCH); chk("e_in", rd_v, 8'h0A);
    wr(`GPEF_ADDR_E_DIR, 8'h03); settle();
    rd(`GPEF_ADDR_E_LATCH); chk("e_mix", rd_v, 8'h09);
    chk("e_oe", {3'h0, e_oe}, 8'h03);
    wr(`GPEF_ADDR_E_DIR, 8'h1F); settle();
    chk("e_drv", {3'h0, e_out}, 8'h15);
  endtask
  task automatic t_port_f();
    f_ext <= 8'h3C; wr(`GPEF_ADDR_F_LATCH, 8'hA5); wr(`GPEF_ADDR_F_DIR, 8'h0F); settle();
    rd(`GPEF_ADDR_F_LATCH); chk("f_mix", rd_v, 8'h35);
    chk("f_oe", f_oe, 8'h0F);
    chk("f_drv", f_out, 8'hA5);
    @(posedge clk_in) resetn_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    wr(`GPEF_ADDR_F_DIR, 8'hFF); settle();
    rd(`GPEF_ADDR_F_LATCH); chk("f_keep", rd_v, 8'hA5);
    wr(`GPEF_ADDR_F_DIR, 8'h00); f_en <= 8'h00; wr(`GPEF_ADDR_F_PULL, 8'hFF); wr(`GPEF_ADDR_F_KBD, 8'hFF); settle();
    rd(`GPEF_ADDR_F_LATCH); chk("f_pull", rd_v, 8'hFF);
    chk("f_pull_out", f_pull, 8'hFF);
    f_en <= 8'hFF; settle(); chk("f_kbd", f_kbd, 8'h3C);
  endtask
  task automatic t_opt_kbd();
    for (int i = 0; i < 8; i++)
    begin
      wr(`GPEF_ADDR_OPT, {i[2:0], ~i[2:0], i[1:0]}); settle();
      chk("opt", {sy, sx, oy, ox}, {i[2:0], ~i[2:0], i[1:0]});
    end
    wr(`GPEF_ADDR_E_DIR, 8'h00); e_en <= 5'h10; wr(`GPEF_ADDR_E_KBD, 8'hFF); settle();
    chk("e_pull", {4'h0, e_pull}, 8'h0F);
    rd(`GPEF_ADDR_E_LATCH); chk("e_pull_rd", rd_v[3:0], 8'h0F);
    chk("e_kbd", {4'h0, e_kbd}, 8'h0F);
  endtask
  task automatic t_timer();
    @(posedge clk_in);
    e_en <= 5'h1F; e_ext <= 5'h01; tim_dir <= 2'b11; tim_out <= 2'b10;
    wr(`GPEF_ADDR_E_LATCH, 8'h00); wr(`GPEF_ADDR_E_KBD, 8'h00); wr(`GPEF_ADDR_TIM_CFG, 8'h07); settle();
    chk("tim_oe", {3'h0, e_oe}, 8'h06);
    rd(`GPEF_ADDR_E_LATCH); chk("tim_rd", rd_v, 8'h05);
    chk("timer_ext_clock_pin", {7'h0, timer_ext_clock_pin}, 8'h01);
    chk("tim_cap", {6'h0, tim_in}, 8'h02);
    wr(`GPEF_ADDR_E_DIR, 8'h1F); settle();
    rd(`GPEF_ADDR_E_LATCH); chk("tim_latch", rd_v, 8'h00);
    @(posedge clk_in) tim_dir <= 2'b00; settle(); chk("tim_dir", {3'h0, e_oe}, 8'h18);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    // A real falling edge at time zero fires the asynchronous reset before the first clock
    resetn_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_reset_vals(); t_port_e(); t_port_f(); t_opt_kbd(); t_timer();
    report_and_stop();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    #(100 * 5000);
    n_mismatch++;
    report_and_stop();
  end
endmodule
